// File: rtl/gcs_pkg.sv
// Package of constants and types for the global configuration and status block.
package gcs_pkg;
  localparam logic [6:0] GCS_ADDR_CONF = 7'h00;
  localparam logic [6:0] GCS_ADDR_FLAGS = 7'h01;
  localparam logic [6:0] GCS_ADDR_COUNT = 7'h02;
  localparam logic [6:0] GCS_ADDR_TARGET = 7'h2d;
  localparam int GCS_BIT_IRQ_PP = 12;
  localparam int GCS_BIT_POS_PP = 13;
  localparam int GCS_BIT_HYST = 14;
  localparam int GCS_BIT_STOP = 15;
  localparam int GCS_BIT_DIRECT = 16;
  localparam int GCS_BIT_TEST = 17;
  localparam int GCS_FLAG_RESET = 0;
  localparam int GCS_FLAG_DRV = 1;
  localparam int GCS_FLAG_UV = 2;
  localparam logic [5:0] GCS_CONF_RESET = 6'h00;
  localparam logic [2:0] GCS_FLAGS_RESET = 3'h1;
  localparam logic [7:0] GCS_COUNT_RESET = 8'h00;
  localparam logic [31:0] GCS_TARGET_RESET = 32'h00000000;

  typedef struct packed {
    logic [5:0] conf;
    logic [2:0] flags;
    logic [7:0] count;
    logic [31:0] target;
  } gcs_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic uart;
    logic [6:0] addr;
    logic [31:0] wdata;
  } gcs_req_t;

  typedef struct packed {
    logic [8:0] coil_a;
    logic [8:0] coil_b;
    logic direct;
  } gcs_coil_t;
endpackage : gcs_pkg

// File: rtl/gcs_regs.sv
// Global configuration bits, global flags and UART write counter.
`timescale 1ns/1ps
module gcs_regs
  import gcs_pkg::*;
(
  input wire logic core_clk_in, // 100 MHz device clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire gcs_req_t req_in, // register access from serial front end
  output logic [31:0] rdata_out, // read data, registered
  input wire logic drv_shutdown_in, // pulse/level: driver shut down by fault
  input wire logic overtemp_in, // level: temperature above limit
  input wire logic pump_undervoltage_flag_in, // level: charge pump undervoltage
  input wire logic halt_input_pin_in, // halt pin level
  input wire logic error_irq_in, // internal error/interrupt, active high
  input wire logic poscmp_in, // internal position compare, active high
  input wire logic [7:0] hyst_value_in, // compared step frequency value
  input wire logic [7:0] standstill_current_scale_in, // standstill current scale
  output logic error_interrupt_pin_o_out, // error pin output level
  output logic error_interrupt_pin_oe_out, // error pin output enable
  output logic position_compare_pin_o_out, // compare pin output level
  output logic position_compare_pin_oe_out, // compare pin output enable
  output logic [7:0] hyst_amount_out, // hysteresis amount for comparison
  output logic seq_stop_out, // stop sequencer, go to standstill
  output gcs_coil_t coil_out, // direct coil current request
  output logic driver_disable_out, // driver disabled
  output logic encoder_null_test_sel_out // analog test on null pin
);
  gcs_state_t q, d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Two's complement value times scale, divided by 32, keeps the sign.
  function automatic logic [8:0] gcs_scale(input logic [8:0] v, input logic [7:0] s);
    logic [16:0] p;
    p = 17'($signed(v) * $signed({1'b0, s}));
    return p[13:5];
  endfunction : gcs_scale

  // ============================================================
  // Register update
  always_comb begin
    d = q;
    rdata_d = rdata_q;
    if (req_in.wr && req_in.addr == GCS_ADDR_CONF) begin
      d.conf = req_in.wdata[GCS_BIT_TEST:GCS_BIT_IRQ_PP];
    end
    if (req_in.wr && req_in.addr == GCS_ADDR_TARGET) begin
      d.target = req_in.wdata;
    end
    if (req_in.wr && req_in.addr == GCS_ADDR_FLAGS) begin
      d.flags[GCS_FLAG_RESET] = q.flags[GCS_FLAG_RESET] & ~req_in.wdata[GCS_FLAG_RESET];
      d.flags[GCS_FLAG_UV] = q.flags[GCS_FLAG_UV] & ~req_in.wdata[GCS_FLAG_UV];
      if (!overtemp_in) begin
        d.flags[GCS_FLAG_DRV] = q.flags[GCS_FLAG_DRV] & ~req_in.wdata[GCS_FLAG_DRV];
      end
    end
    // Set wins over a clear in the same cycle.
    if (drv_shutdown_in) begin
      d.flags[GCS_FLAG_DRV] = 1'b1;
    end
    if (pump_undervoltage_flag_in) begin
      d.flags[GCS_FLAG_UV] = 1'b1;
    end
    if (req_in.wr && req_in.uart) begin
      d.count = q.count + 8'h01;
    end
    if (req_in.rd) begin
      case (req_in.addr)
        GCS_ADDR_CONF: rdata_d = 32'({q.conf, 12'h000});
        GCS_ADDR_FLAGS: rdata_d = 32'(q.flags);
        GCS_ADDR_COUNT: rdata_d = 32'(q.count);
        GCS_ADDR_TARGET: rdata_d = q.target;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      q <= '{conf: GCS_CONF_RESET, flags: GCS_FLAGS_RESET, count: GCS_COUNT_RESET,
             target: GCS_TARGET_RESET};
      rdata_q <= 32'h00000000;
    end else begin
      q <= d;
      rdata_q <= rdata_d;
    end
  end
  assign rdata_out = rdata_q;

  // ============================================================
  // Pin styles and feature outputs
  logic irq_pp, pos_pp;
  assign irq_pp = q.conf[GCS_BIT_IRQ_PP - GCS_BIT_IRQ_PP];
  assign pos_pp = q.conf[GCS_BIT_POS_PP - GCS_BIT_IRQ_PP];
  // Open collector drives low only when active; push-pull always drives.
  assign error_interrupt_pin_o_out = irq_pp ? error_irq_in : 1'b0;
  assign error_interrupt_pin_oe_out = irq_pp ? 1'b1 : error_irq_in;
  assign position_compare_pin_o_out = pos_pp ? poscmp_in : 1'b0;
  assign position_compare_pin_oe_out = pos_pp ? 1'b1 : poscmp_in;
  assign hyst_amount_out = q.conf[GCS_BIT_HYST - GCS_BIT_IRQ_PP] ?
                           (hyst_value_in >> 5) : (hyst_value_in >> 4);
  assign seq_stop_out = q.conf[GCS_BIT_STOP - GCS_BIT_IRQ_PP] & halt_input_pin_in;
  assign coil_out.direct = q.conf[GCS_BIT_DIRECT - GCS_BIT_IRQ_PP];
  // Velocity-based regulation is bypassed: only standstill scale applies.
  assign coil_out.coil_a = gcs_scale(q.target[8:0], standstill_current_scale_in);
  assign coil_out.coil_b = gcs_scale(q.target[24:16], standstill_current_scale_in);
  assign driver_disable_out = pump_undervoltage_flag_in | overtemp_in;
  assign encoder_null_test_sel_out = q.conf[GCS_BIT_TEST - GCS_BIT_IRQ_PP];

  // ============================================================
  // Checks
  flag_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    req_in.wr && req_in.addr == GCS_ADDR_FLAGS && req_in.wdata[0] |=> !q.flags[0])
    else $error("reset flag not cleared");
  drv_keep_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    q.flags[1] && overtemp_in |=> q.flags[1])
    else $error("driver fault cleared while hot");
  drv_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    drv_shutdown_in |=> q.flags[1])
    else $error("driver fault not set");
  uv_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    pump_undervoltage_flag_in |=> q.flags[2])
    else $error("undervoltage not latched");
  uv_disable_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    pump_undervoltage_flag_in |-> driver_disable_out)
    else $error("driver enabled in undervoltage");
  count_wrap_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    req_in.wr && req_in.uart && q.count == 8'hff |=> q.count == 8'h00)
    else $error("counter did not wrap");
  count_idle_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    req_in.wr && !req_in.uart |=> q.count == $past(q.count))
    else $error("counter stepped on spi write");
  irq_style_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !irq_pp |-> !error_interrupt_pin_o_out && error_interrupt_pin_oe_out == error_irq_in)
    else $error("error pin not open collector");
  pos_style_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    pos_pp |-> position_compare_pin_oe_out && position_compare_pin_o_out == poscmp_in)
    else $error("compare pin not push-pull");
  test_sel_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    encoder_null_test_sel_out == q.conf[5])
    else $error("test select wrong");
  count_inc_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    req_in.wr && req_in.uart |=> q.count == 8'($past(q.count) + 8'h01))
    else $error("counter did not step");
  count_spi_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !(req_in.wr && req_in.uart) |=> $stable(q.count))
    else $error("counter changed without uart write");
  reset_flag_a: assert property (@(posedge core_clk_in)
    !resetn_in |=> q.flags[0])
    else $error("reset flag missing");
  stop_pin_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    q.conf[3] && halt_input_pin_in |-> seq_stop_out)
    else $error("halt ignored");
endmodule : gcs_regs

// File: bench/gcs_host.sv
// Host model that issues single register accesses to the block.
`timescale 1ns/1ps
module gcs_host
  import gcs_pkg::*;
(
  input wire logic core_clk_in, // device clock
  output gcs_req_t req_out // register request towards the block
);
  initial req_out = '0;
  // Strobes last one cycle; address and data stay until the next access.
  task automatic xfer(input logic w, input logic u, input logic [6:0] a, input logic [31:0] d);
    @(negedge core_clk_in);
    req_out = '{wr: w, rd: !w, uart: u, addr: a, wdata: d};
    @(negedge core_clk_in);
    req_out.wr = 1'b0;
    req_out.rd = 1'b0;
  endtask : xfer
endmodule : gcs_host

// File: bench/test_global_config_status_regs.sv
// Self-checking testbench of the global configuration and status block.
`timescale 1ns/1ps
module test_global_config_status_regs
  import gcs_pkg::*;
;
  logic clk = 0, rstn = 0, drv = 0, ot = 0, uv = 0, halt = 0, irq = 0, pc = 0;
  logic eo, ee, po, pe, stop, dis, tsel;
  logic [7:0] hv = 8'h00, sc = 8'h10, hyst, cnt = 8'h00;
  logic [31:0] rd, r, seed = 32'h82dc;
  gcs_req_t req;
  gcs_coil_t coil;
  int n_fail = 0, comparisons = 0;
  gcs_regs gcs_regs_i(.core_clk_in(clk), .resetn_in(rstn), .req_in(req), .rdata_out(rd),
    .drv_shutdown_in(drv), .overtemp_in(ot), .pump_undervoltage_flag_in(uv), .halt_input_pin_in(halt),
    .error_irq_in(irq), .poscmp_in(pc), .hyst_value_in(hv), .standstill_current_scale_in(sc),
    .error_interrupt_pin_o_out(eo), .error_interrupt_pin_oe_out(ee),
    .position_compare_pin_o_out(po), .position_compare_pin_oe_out(pe),
    .hyst_amount_out(hyst), .seq_stop_out(stop), .coil_out(coil),
    .driver_disable_out(dis), .encoder_null_test_sel_out(tsel));
  gcs_host gcs_host_i(.core_clk_in(clk), .req_out(req));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Open collector pulls low while active; push-pull drives the level. Result is {o, oe}.
  function automatic logic [1:0] pin(input logic pp, input logic act);
    return pp ? {act, 1'b1} : {1'b0, act};
  endfunction : pin
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check
  task automatic rdc(input logic [6:0] a, input logic [31:0] e, input string m);
    gcs_host_i.xfer(1'b0, 1'b1, a, 32'h0);
    @(negedge clk);
    check(rd, e, m);
  endtask : rdc
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    #20us;
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1;
    rdc(GCS_ADDR_FLAGS, 32'h1, "reset flag");
    gcs_host_i.xfer(1'b1, 1'b0, GCS_ADDR_FLAGS, 32'h1);
    rdc(GCS_ADDR_FLAGS, 32'h0, "clear");
    rdc(GCS_ADDR_COUNT, 32'h0, "spi write counted");
    ot = 1;
    drv = 1;
    uv = 1;
    @(negedge clk);
    drv = 0;
    check(dis, 1'b1, "driver enabled in undervoltage");
    gcs_host_i.xfer(1'b1, 1'b1, GCS_ADDR_FLAGS, 32'h3);
    rdc(GCS_ADDR_FLAGS, 32'h6, "fault cleared while hot");
    ot = 0;
    uv = 0;
    #1;
    check(dis, 1'b0, "driver disabled without fault");
    gcs_host_i.xfer(1'b1, 1'b1, GCS_ADDR_FLAGS, 32'h2);
    rdc(GCS_ADDR_FLAGS, 32'h4, "fault clear");
    cnt = 8'h02;
    rdc(GCS_ADDR_COUNT, {24'h0, cnt}, "count");
    rdc(GCS_ADDR_COUNT, {24'h0, cnt}, "count after read");
    $display("flag test done");
    repeat (8) begin
      r = rnd();
      gcs_host_i.xfer(1'b1, 1'b1, GCS_ADDR_CONF, r);
      cnt++;
      irq = r[0];
      pc = r[1];
      halt = r[2];
      hv = r[31:24];
      #1;
      check({eo, ee}, pin(r[12], irq), "error pin");
      check({po, pe}, pin(r[13], pc), "compare pin");
      check(hyst, r[14] ? hv >> 5 : hv >> 4, "hysteresis");
      check(stop, r[15] & halt, "stop");
      check(coil.direct, r[16], "direct");
      check(tsel, r[17], "test select");
    end
    gcs_host_i.xfer(1'b1, 1'b1, GCS_ADDR_TARGET, 32'h01c0_0040);
    cnt++;
    #1;
    check(coil.coil_a, 9'h020, "coil a");
    check(coil.coil_b, 9'h1e0, "coil b");
    $display("config test done");
    repeat (255) gcs_host_i.xfer(1'b1, 1'b1, GCS_ADDR_COUNT, rnd());
    cnt = cnt + 8'hff;
    rdc(GCS_ADDR_COUNT, {24'h0, cnt}, "wrap");
    rstn = 0;
    repeat (2) @(negedge clk);
    rstn = 1;
    rdc(GCS_ADDR_FLAGS, 32'h1, "second reset flag");
    rdc(GCS_ADDR_COUNT, 32'h0, "counter after reset");
    $display("counter test done");
    stop_test();
  end
endmodule : test_global_config_status_regs
